// [pkg/fpc_defs.svh]
/*
 * Constants of the front-panel console block: register offsets, reset values,
 * response codes and bit positions of the synchronised pin vector.
 * Assumes inclusion by bare name from the package and the bench.
 */
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// register byte offsets
`define FPC_STATUS_OFS     8'h00
`define FPC_DISPLAY_OFS    8'h04
`define FPC_DISP_SEL_OFS   8'h08
`define FPC_PANEL_DATA_OFS 8'h0C
`define FPC_MEM_ADDR_OFS   8'h10
`define FPC_PROG_CNT_OFS   8'h14

// reset values
`define FPC_DISP_SEL_RST   2'h0
`define FPC_PANEL_DATA_RST 16'h0000
`define FPC_WORD_RST       16'h0000

// axi responses
`define FPC_RESP_OKAY      2'b00
`define FPC_RESP_SLVERR    2'b10

// bit positions in the synchronised pin vector
`define FPC_PIN_UNLOCK     0
`define FPC_PIN_FSW        1
`define FPC_PIN_START      2
`define FPC_PIN_HALT       3
`define FPC_PIN_RUN        4
`define FPC_PIN_SINGLE     5
`define FPC_PIN_CLK_ON     6
`define FPC_PIN_STEP       7
`define FPC_PIN_JUMPER     8
`define FPC_PIN_RESET      9
`define FPC_PIN_DISPLAY    10
`define FPC_PIN_SSET       11
`define FPC_PIN_SCLR       15
`define FPC_PIN_W          19

`endif

// [pkg/fpc_pkg.sv]
/*
 * Types of the front-panel console block: sequencer states and the packed
 * state record. Assumes fpc_defs.svh is on the include path.
 */
`include "fpc_defs.svh"

package fpc_pkg;

    // console subroutine, reset and instruction states
    typedef enum logic [3:0] {
        FPC_D0, FPC_D1, FPC_D2, FPC_D3, FPC_D4, FPC_D5, FPC_D6, FPC_D7,
        FPC_D8, FPC_D9, FPC_SHOW, FPC_E0, FPC_E2, FPC_EXEC
    } fpc_seq_t;

    typedef struct packed {
        logic [`FPC_PIN_W-1:0] sync1;
        logic [`FPC_PIN_W-1:0] sync2;
        logic fsw_active;
        logic start_prev;
        logic start_pulse;
        logic step_prev;
        logic step_pulse_n;
        logic run_flag;
        logic [3:0] sense_latch;
        logic [3:0] sense_reg;
        fpc_seq_t seq;
        logic [15:0] mem_addr;
        logic [15:0] prog_cnt;
        logic [15:0] status_word;
        logic [15:0] display_register;
        logic mem_req;
        logic [1:0] disp_sel;
        logic [15:0] panel_data;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpc_state_t;

endpackage

// [logic/fpc_console.sv]
/*
 * Front-panel console control: pin synchronisers, panel lock gate, function
 * and start pulses, clock gating and step pulse, sense-switch capture, the
 * console microsequencer with its registers, and an AXI4-Lite slave.
 * Assumes debounced switch levels on the pins and the clock-line consumers
 * honouring proc_clk_en; the memory controller keeps its own refresh.
 */
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - lock switch level registered on system clock
// - locked panel suppresses function, start, step, reset, display and halt signals
// - locked running machine ignores halt position
// - function pulse flop drives shared return low
// - active function switch holds sequencer in D0
// - start gives one-clock pulse, sets run flag
// - jumper forces clock gate on, else switch
// - step position yields one one-clock low pulse
// - step pulse advances one state, drives clock line
// - four sense latches into 4-bit register
// - run and single positions pass through unfiltered
// - halted sequencer waits in D0 while switch active
// - idle loop cycles D1 through D9
// - D1 with run flag goes to E0
// - outside console only mode and clock matter
// - halt position clears run flag
// - reset in D1 zeroes registers via E2
// - single mode clears run at first execution
// - display loads on enable, continuously when off
// - display switch routes selected register to display
module fpc_console
    import fpc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lock_unlock_pin,
    input wire logic func_switch_pin,
    input wire logic start_switch_pin,
    input wire logic mode_halt_pin,
    input wire logic run_position_pin,
    input wire logic single_step_position_pin,
    input wire logic clock_switch_on_pin,
    input wire logic clock_switch_step_pin,
    input wire logic clock_jumper_pin,
    input wire logic reset_switch_pin,
    input wire logic display_switch_pin,
    input wire logic [3:0] sense_set_pin,
    input wire logic [3:0] sense_clear_pin,
    input wire logic [15:0] alu_data,
    input wire logic display_load_enable_n,
    output logic panel_unlocked_sync,
    output logic function_switch_active,
    output logic start_pulse,
    output logic run_flag,
    output logic clock_gate_on,
    output logic step_pulse_n,
    output logic proc_clk_en,
    output logic switch_return_o,
    output logic switch_return_oe,
    output logic run_position_signal,
    output logic single_step_position_signal,
    output logic [3:0] sense_bits,
    output logic [15:0] display_register,
    output logic mem_cycle_req,
    output logic [3:0] seq_state,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    fpc_state_t cur_ff;
    fpc_state_t nxt_cur;
    logic [`FPC_PIN_W-1:0] pins;
    logic unlocked;
    logic adv;
    logic fsw_g;
    logic reset_g;
    logic display_g;
    logic halt_g;
    logic single_mode;
    logic [15:0] alu_bus;
    logic [15:0] sel_word;
    logic aw_hs;
    logic w_hs;
    logic dr_load;
    logic [15:0] wr_lo;

    // raw pins gathered for the synchroniser
    assign pins = {sense_clear_pin, sense_set_pin, display_switch_pin, reset_switch_pin,
                   clock_jumper_pin, clock_switch_step_pin, clock_switch_on_pin,
                   single_step_position_pin, run_position_pin, mode_halt_pin,
                   start_switch_pin, func_switch_pin, lock_unlock_pin};

    // gated console controls, taken from the second synchroniser stage
    assign unlocked = cur_ff.sync2[`FPC_PIN_UNLOCK];
    assign fsw_g = cur_ff.sync2[`FPC_PIN_FSW] & unlocked;
    assign reset_g = cur_ff.sync2[`FPC_PIN_RESET] & unlocked;
    assign display_g = cur_ff.sync2[`FPC_PIN_DISPLAY] & unlocked;
    assign halt_g = cur_ff.sync2[`FPC_PIN_HALT] & unlocked;
    assign single_mode = cur_ff.sync2[`FPC_PIN_SINGLE];
    assign clock_gate_on = cur_ff.sync2[`FPC_PIN_JUMPER] | cur_ff.sync2[`FPC_PIN_CLK_ON];
    assign adv = clock_gate_on | ~cur_ff.step_pulse_n;

    // register picked by the display function
    always_comb begin
        unique case (cur_ff.disp_sel)
            2'h0: sel_word = cur_ff.mem_addr;
            2'h1: sel_word = cur_ff.prog_cnt;
            2'h2: sel_word = cur_ff.status_word;
            default: sel_word = cur_ff.panel_data;
        endcase
    end

    // internal alu bus: zero in reset state, selected register when showing
    always_comb begin
        if (cur_ff.seq == FPC_E2) begin
            alu_bus = `FPC_WORD_RST;
        end else if (cur_ff.seq == FPC_SHOW) begin
            alu_bus = sel_word;
        end else begin
            alu_bus = alu_data;
        end
    end

    // display load: enable strobe with clocks on, every cycle with clocks off
    assign dr_load = clock_gate_on ? (~display_load_enable_n | cur_ff.seq == FPC_SHOW) : 1'b1;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign wr_lo = w_hs ? s_axi_wdata[15:0] : cur_ff.wdata[15:0];

    // next state of the whole block
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.sync1 = pins;
        nxt_cur.sync2 = cur_ff.sync1;
        // function pulse flop and start pulse flop
        nxt_cur.fsw_active = fsw_g;
        nxt_cur.start_prev = cur_ff.sync2[`FPC_PIN_START] & unlocked;
        nxt_cur.start_pulse = cur_ff.sync2[`FPC_PIN_START] & unlocked & ~cur_ff.start_prev;
        // step pulse only when the switch can act
        nxt_cur.step_prev = cur_ff.sync2[`FPC_PIN_STEP];
        nxt_cur.step_pulse_n = ~(cur_ff.sync2[`FPC_PIN_STEP] & ~cur_ff.step_prev
                                 & ~cur_ff.sync2[`FPC_PIN_JUMPER] & unlocked);
        // sense latches then the sense register
        nxt_cur.sense_latch = (cur_ff.sense_latch & ~cur_ff.sync2[`FPC_PIN_SCLR +: 4])
                              | cur_ff.sync2[`FPC_PIN_SSET +: 4];
        nxt_cur.sense_reg = cur_ff.sense_latch;
        if (dr_load) begin
            nxt_cur.display_register = alu_bus;
        end
        nxt_cur.mem_req = 1'b0;
        // run flag: halt clears unless locked, start wins over the clear
        if (halt_g) begin
            nxt_cur.run_flag = 1'b0;
        end
        if (adv) begin
            unique case (cur_ff.seq)
                FPC_D0: begin
                    // a held reset switch parks here too, so E2 runs once per press
                    if (!cur_ff.fsw_active && !reset_g) begin
                        nxt_cur.seq = FPC_D1;
                    end
                end
                FPC_D1: begin
                    if (cur_ff.run_flag) begin
                        nxt_cur.seq = FPC_E0;
                    end else if (reset_g) begin
                        nxt_cur.seq = FPC_E2;
                    end else begin
                        nxt_cur.seq = FPC_D2;
                    end
                end
                FPC_D2: begin
                    nxt_cur.seq = display_g ? FPC_SHOW : FPC_D3;
                end
                FPC_D3: nxt_cur.seq = FPC_D4;
                FPC_D4: nxt_cur.seq = FPC_D5;
                FPC_D5: nxt_cur.seq = FPC_D6;
                FPC_D6: nxt_cur.seq = FPC_D7;
                FPC_D7: nxt_cur.seq = FPC_D8;
                FPC_D8: nxt_cur.seq = FPC_D9;
                FPC_D9: nxt_cur.seq = cur_ff.fsw_active ? FPC_D0 : FPC_D1;
                FPC_SHOW: nxt_cur.seq = FPC_D0;
                FPC_E2: begin
                    nxt_cur.mem_addr = alu_bus;
                    nxt_cur.prog_cnt = alu_bus;
                    nxt_cur.status_word = alu_bus;
                    nxt_cur.display_register = alu_bus;
                    nxt_cur.seq = FPC_D0;
                end
                FPC_E0: begin
                    // instruction acquisition; only mode and clock reach here
                    nxt_cur.mem_addr = cur_ff.prog_cnt;
                    nxt_cur.prog_cnt = cur_ff.prog_cnt + 16'h0001;
                    nxt_cur.mem_req = 1'b1;
                    nxt_cur.seq = FPC_EXEC;
                    if (single_mode) begin
                        nxt_cur.run_flag = 1'b0;
                    end
                end
                FPC_EXEC: begin
                    nxt_cur.seq = cur_ff.run_flag ? FPC_E0 : FPC_D0;
                end
                default: nxt_cur.seq = FPC_D0;
            endcase
        end
        if (cur_ff.start_pulse) begin
            nxt_cur.run_flag = 1'b1;
        end
        // axi write channels taken in either order
        if (aw_hs) begin
            nxt_cur.aw_got = 1'b1;
            nxt_cur.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            nxt_cur.w_got = 1'b1;
            nxt_cur.wdata = s_axi_wdata;
            nxt_cur.wstrb = s_axi_wstrb;
        end
        if ((cur_ff.aw_got | aw_hs) & (cur_ff.w_got | w_hs) & ~cur_ff.bvalid) begin
            nxt_cur.aw_got = 1'b0;
            nxt_cur.w_got = 1'b0;
            nxt_cur.bvalid = 1'b1;
            nxt_cur.bresp = `FPC_RESP_OKAY;
            unique case (aw_hs ? s_axi_awaddr : cur_ff.awaddr)
                `FPC_DISP_SEL_OFS: begin
                    if ((w_hs ? s_axi_wstrb[0] : cur_ff.wstrb[0])) begin
                        nxt_cur.disp_sel = wr_lo[1:0];
                    end
                end
                `FPC_PANEL_DATA_OFS: begin
                    if ((w_hs ? s_axi_wstrb[0] : cur_ff.wstrb[0])) begin
                        nxt_cur.panel_data[7:0] = wr_lo[7:0];
                    end
                    if ((w_hs ? s_axi_wstrb[1] : cur_ff.wstrb[1])) begin
                        nxt_cur.panel_data[15:8] = wr_lo[15:8];
                    end
                end
                `FPC_STATUS_OFS, `FPC_DISPLAY_OFS, `FPC_MEM_ADDR_OFS,
                `FPC_PROG_CNT_OFS: nxt_cur.bresp = `FPC_RESP_OKAY;
                default: nxt_cur.bresp = `FPC_RESP_SLVERR;
            endcase
        end
        if (cur_ff.bvalid & s_axi_bready) begin
            nxt_cur.bvalid = 1'b0;
        end
        // axi read, answered in the cycle after the address is taken
        if (cur_ff.rvalid & s_axi_rready) begin
            nxt_cur.rvalid = 1'b0;
        end
        if (s_axi_arvalid & ~cur_ff.rvalid) begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rresp = `FPC_RESP_OKAY;
            nxt_cur.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                `FPC_STATUS_OFS: nxt_cur.rdata = {16'h0000, cur_ff.sense_reg, cur_ff.seq,
                    3'h0, cur_ff.fsw_active, unlocked, clock_gate_on, 1'b0, cur_ff.run_flag};
                `FPC_DISPLAY_OFS: nxt_cur.rdata = {16'h0000, cur_ff.display_register};
                `FPC_DISP_SEL_OFS: nxt_cur.rdata = {30'h0000_0000, cur_ff.disp_sel};
                `FPC_PANEL_DATA_OFS: nxt_cur.rdata = {16'h0000, cur_ff.panel_data};
                `FPC_MEM_ADDR_OFS: nxt_cur.rdata = {16'h0000, cur_ff.mem_addr};
                `FPC_PROG_CNT_OFS: nxt_cur.rdata = {16'h0000, cur_ff.prog_cnt};
                default: nxt_cur.rresp = `FPC_RESP_SLVERR;
            endcase
        end
    end

    // single register stage for all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_ff <= '0;
            cur_ff.step_pulse_n <= 1'b1;
            cur_ff.seq <= FPC_D0;
            cur_ff.disp_sel <= `FPC_DISP_SEL_RST;
            cur_ff.panel_data <= `FPC_PANEL_DATA_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs
    assign panel_unlocked_sync = unlocked;
    assign function_switch_active = cur_ff.fsw_active;
    assign start_pulse = cur_ff.start_pulse;
    assign run_flag = cur_ff.run_flag;
    assign step_pulse_n = cur_ff.step_pulse_n;
    assign proc_clk_en = adv;
    assign switch_return_o = 1'b0;
    assign switch_return_oe = cur_ff.fsw_active;
    assign run_position_signal = cur_ff.sync2[`FPC_PIN_RUN];
    assign single_step_position_signal = single_mode;
    assign sense_bits = cur_ff.sense_reg;
    assign display_register = cur_ff.display_register;
    assign mem_cycle_req = cur_ff.mem_req;
    assign seq_state = cur_ff.seq;
    assign s_axi_awready = ~cur_ff.aw_got & ~cur_ff.bvalid;
    assign s_axi_wready = ~cur_ff.w_got & ~cur_ff.bvalid;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_arready = ~cur_ff.rvalid;
    assign s_axi_rvalid = cur_ff.rvalid;
    assign s_axi_rdata = cur_ff.rdata;
    assign s_axi_rresp = cur_ff.rresp;

    default clocking fpc_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // checks next to the logic they guard
    lock_gate_a: assert property (!unlocked |=> !start_pulse && !function_switch_active)
        else $error("locked panel passed a control");
    locked_run_a: assert property (run_flag && !unlocked && !(cur_ff.seq == FPC_E0 && adv)
        |=> run_flag)
        else $error("locked run flag cleared");
    start_one_a: assert property (start_pulse |=> !start_pulse)
        else $error("start pulse longer than one clock");
    start_run_a: assert property (start_pulse |=> run_flag)
        else $error("start pulse did not set run");
    jumper_on_a: assert property (cur_ff.sync2[`FPC_PIN_JUMPER] |-> clock_gate_on
        && step_pulse_n)
        else $error("jumper did not force clock on");
    step_one_a: assert property (!step_pulse_n |=> step_pulse_n ##1 step_pulse_n)
        else $error("step pulse repeated");
    d0_hold_a: assert property (cur_ff.seq == FPC_D0 && cur_ff.fsw_active && adv
        |=> cur_ff.seq == FPC_D0)
        else $error("left D0 with switch active");
    d1_run_a: assert property (cur_ff.seq == FPC_D1 && run_flag && adv
        |=> cur_ff.seq == FPC_E0)
        else $error("run flag did not reach E0");
    reset_zero_a: assert property (cur_ff.seq == FPC_E2 && adv |=> cur_ff.prog_cnt == 16'h0000
        && cur_ff.mem_addr == 16'h0000 && display_register == 16'h0000 && seq_state == FPC_D0)
        else $error("reset did not zero registers");
    halt_clear_a: assert property (halt_g && !start_pulse |=> !run_flag)
        else $error("halt did not clear run");
    single_clr_a: assert property (cur_ff.seq == FPC_E0 && adv && single_mode
        && !start_pulse |=> !run_flag ##1 seq_state == FPC_D0)
        else $error("single mode ran on");
    sense_path_a: assert property (##1 sense_bits == $past(cur_ff.sense_latch))
        else $error("sense register lost latch");
    dr_free_a: assert property (aresetn && !clock_gate_on && cur_ff.seq != FPC_E2
        |=> display_register == $past(alu_bus))
        else $error("display not loading with clocks off");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    // switch return check, then sequencing checks for the stepped clock, reset hold and running state
    ret_line_a: assert property (fsw_g |=> switch_return_oe && !switch_return_o)
        else $error("switch return not pulled");
    clock_hold_a: assert property (!clock_gate_on && step_pulse_n
        |=> seq_state == $past(seq_state))
        else $error("sequencer moved with clocks off");
    reset_wait_a: assert property (cur_ff.seq == FPC_D0 && reset_g && adv
        |=> cur_ff.seq == FPC_D0)
        else $error("left D0 with reset held");
    run_keep_a: assert property (cur_ff.seq == FPC_EXEC && run_flag && adv
        |=> cur_ff.seq == FPC_E0)
        else $error("running machine took a console switch");

endmodule

// [verif/fpc_proc_model.sv]
/*
 * Processor-side partner of the console: ALU bus, display load strobe and a
 * memory controller that serves requested cycles while refresh keeps running.
 * Assumes one clock shared with the console and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module fpc_proc_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic strobe_on,
    input wire logic mem_cycle_req,
    output logic [15:0] alu_data,
    output logic display_load_enable_n,
    output int served
);
    int refresh;
    // alu bus moves every cycle so a stale capture never matches
    always_ff @(posedge aclk) begin
        alu_data <= alu_data + 16'h0101;
        display_load_enable_n <= !strobe_on;
        refresh <= refresh + 1;
        if (!aresetn) begin
            alu_data <= 16'h0001;
            served <= 0;
        end else if (mem_cycle_req) begin
            served <= served + 1;
        end
    end
endmodule

// [verif/tb_top.sv]
/*
 * Self-checking bench of the console: pin scenarios and AXI4-Lite accesses.
 * Assumes the package, the console and the partner model are compiled first.
 */
`timescale 1ns/100ps
`include "fpc_defs.svh"
module tb_top import fpc_pkg::*; ;
    logic aclk = 0, aresetn = 0;
    logic lock, fsw, start, halt, runp, sglp, con, step, jmp, rsw, dsw, strobe;
    logic [3:0] sset, sclr, sbits, seq, wstrb;
    logic unl, fact, spul, runf, cgo, stpn, pce, sro, sroe, mreq, dle_n, rps, sps;
    logic [15:0] disp, alu, a;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    int n_fail = 0, num_checks = 0, served, c_sp, c_st, c_pe;
    int hist [16];
    fpc_console i_dut (.aclk(aclk), .aresetn(aresetn), .lock_unlock_pin(lock),
        .func_switch_pin(fsw), .start_switch_pin(start), .mode_halt_pin(halt),
        .run_position_pin(runp), .single_step_position_pin(sglp),
        .clock_switch_on_pin(con), .clock_switch_step_pin(step), .clock_jumper_pin(jmp),
        .reset_switch_pin(rsw), .display_switch_pin(dsw), .sense_set_pin(sset),
        .sense_clear_pin(sclr), .alu_data(alu), .display_load_enable_n(dle_n),
        .panel_unlocked_sync(unl), .function_switch_active(fact), .start_pulse(spul),
        .run_flag(runf), .clock_gate_on(cgo), .step_pulse_n(stpn), .proc_clk_en(pce),
        .switch_return_o(sro), .switch_return_oe(sroe), .run_position_signal(rps),
        .single_step_position_signal(sps), .sense_bits(sbits), .display_register(disp),
        .mem_cycle_req(mreq), .seq_state(seq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    fpc_proc_model i_proc (.aclk(aclk), .aresetn(aresetn), .strobe_on(strobe),
        .mem_cycle_req(mreq), .alu_data(alu), .display_load_enable_n(dle_n),
        .served(served));
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // one write, both channels offered together, bready held until bvalid
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        int n;
        logic bd;
        n = 0;
        bd = 0;
        rs = 2'bxx;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!bd && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) begin
                bd = 1;
                rs = bresp;
                bready <= 0;
            end
        end
        if (!bd) chk(0, 1, "write hang");
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        int n;
        logic dn;
        n = 0;
        dn = 0;
        dt = 'x;
        rs = 2'bxx;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1;
        rready <= 1;
        while (!dn && n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) begin
                dn = 1;
                dt = rdata;
                rs = rresp;
                rready <= 0;
            end
        end
        if (!dn) chk(0, 1, "read hang");
    endtask
    // watch n cycles, start, step, reset and display pins released after eleven
    task automatic watch(input int n);
        c_sp = 0;
        c_st = 0;
        c_pe = 0;
        foreach (hist[i]) hist[i] = 0;
        for (int i = 0; i < n; i++) begin
            cyc(1);
            c_sp += int'(spul === 1'b1);
            c_st += int'(stpn === 1'b0);
            c_pe += int'(pce === 1'b1);
            hist[seq]++;
            if (i == 10) {start, step, rsw, dsw} <= 4'h0;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        cyc(20000);
        n_fail++;
        end_of_test();
    end
    initial begin
        {lock, fsw, start, halt, runp, sglp, step, jmp, rsw, dsw, strobe} = '0;
        {con, sset, sclr, awvalid, wvalid, bready, arvalid, rready} = 14'h2000;
        {awaddr, araddr, wdata, wstrb} = '0;
        cyc(20);
        chk(runf, 0, "run after reset");
        chk(stpn, 1, "step after reset");
        chk(disp, 0, "display after reset");
        aresetn <= 1;
        lock <= 1;
        cyc(4);
        chk(unl, 1, "unlocked");
        lock <= 0;
        cyc(1);
        chk(unl, 1, "lock passed unregistered");
        cyc(4);
        chk(unl, 0, "locked");
        {runp, start, fsw} <= 3'h7;
        watch(30);
        chk(runf, 0, "start while locked");
        chk(sroe, 0, "return while locked");
        fsw <= 0;
        lock <= 1;
        cyc(4);
        start <= 1;
        watch(40);
        chk(c_sp, 1, "start pulse count");
        chk(runf, 1, "run after start");
        chk(hist[FPC_E0] > 0, 1, "e0 reached");
        chk(served > 0, 1, "memory cycles");
        rsw <= 1;
        cyc(20);
        rd(`FPC_PROG_CNT_OFS, d, r);
        chk(d == 0, 0, "reset ignored while running");
        rsw <= 0;
        $display("test start done");
        lock <= 0;
        halt <= 1;
        cyc(10);
        chk(runf, 1, "halt while locked");
        lock <= 1;
        watch(20);
        chk(runf, 0, "halt clears run");
        chk(hist[FPC_D0] > 0, 1, "halt back to d0");
        {halt, runp, sglp, start} <= 4'h3;
        watch(40);
        chk(hist[FPC_E0], 1, "single instruction");
        chk(runf, 0, "single clears run");
        chk({rps, sps}, 2'b01, "mode positions passed");
        fsw <= 1;
        cyc(16);
        chk({sro, sroe, fact}, 3'h3, "function return");
        watch(20);
        chk(hist[FPC_D0], 20, "hold in d0");
        fsw <= 0;
        watch(40);
        chk(hist[FPC_D9] > 0, 1, "idle loop");
        rsw <= 1;
        watch(40);
        chk(hist[FPC_E2] > 0, 1, "reset path");
        rd(`FPC_MEM_ADDR_OFS, d, r);
        chk({r, d}, 0, "mem addr cleared");
        rd(`FPC_PROG_CNT_OFS, d, r);
        chk({r, d}, 0, "counter cleared");
        chk(disp, 0, "display cleared");
        $display("test reset done");
        wr(`FPC_DISP_SEL_OFS, 32'h0000_0003, r);
        wr(`FPC_PANEL_DATA_OFS, 32'h0000_1234, r);
        rd(`FPC_DISP_SEL_OFS, d, r);
        chk({r, d}, 34'h0_0000_0003, "select readback");
        dsw <= 1;
        watch(40);
        chk(disp, 16'h1234, "display routed");
        wr(8'h40, 32'h0000_ffff, r);
        chk(r, `FPC_RESP_SLVERR, "unmapped write");
        rd(8'h40, d, r);
        chk({r, d}, {`FPC_RESP_SLVERR, 32'h0000_0000}, "unmapped read");
        strobe <= 1;
        cyc(3);
        a = alu;
        cyc(1);
        chk(disp, a, "strobed load");
        strobe <= 0;
        con <= 0;
        cyc(4);
        chk(cgo, 0, "clock off");
        a = alu;
        cyc(1);
        chk(disp, a, "continuous load");
        step <= 1;
        watch(40);
        chk(c_st, 1, "one step pulse");
        chk(c_pe, 1, "one clock enable");
        jmp <= 1;
        cyc(4);
        chk(cgo, 1, "jumper forces clock");
        step <= 1;
        watch(40);
        chk(c_st, 0, "step with jumper");
        {jmp, con, sset} <= 6'h15;
        cyc(2);
        sset <= 4'h0;
        cyc(6);
        chk(sbits, 4'h5, "sense set");
        sclr <= 4'hf;
        cyc(2);
        sclr <= 4'h0;
        cyc(6);
        chk(sbits, 4'h0, "sense clear");
        $display("test panel done");
        end_of_test();
    end
endmodule
